//--- rtl/urb_pkg.sv
// shared constants and types for the usart receive buffer block
package urb_pkg;
  // timing
  localparam int unsigned CLK_HZ     = 25_000_000;
  localparam int unsigned BAUD_RATE  = 9600;
  localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_RATE;
  // register byte offsets
  localparam logic [7:0] OFF_STATUS  = 8'h00;
  localparam logic [7:0] OFF_CONTROL = 8'h04;
  localparam logic [7:0] OFF_FRAME   = 8'h08;
  localparam logic [7:0] OFF_DATA    = 8'h0c;
  // serial_status_reg fields
  localparam int ST_UNREAD = 7;
  localparam int ST_FE     = 4;
  localparam int ST_LOST   = 3;
  localparam int ST_PE     = 2;
  // serial_control_reg fields
  localparam int CT_IRQ_EN = 7;
  localparam int CT_RX_ON  = 4;
  localparam int CT_NINTH  = 1;
  // frame_config_reg fields
  localparam int FC_PAR_ON = 5;
  localparam int FC_ODD    = 4;
  localparam int FC_STOP2  = 3;
  localparam int FC_SIZE   = 0;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] FRAME_RST   = 8'h03;
  localparam logic [2:0] CHAR_SIZE9  = 3'h7;
  // buffer entry layout
  localparam int ENT_W    = 12;
  localparam int ENT_PE   = 9;
  localparam int ENT_FE   = 10;
  localparam int ENT_LOST = 11;
  localparam int BUF_DEPTH = 2;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} urb_rx_state_t;
endpackage : urb_pkg

//--- rtl/urb_frame_if.sv
// received frame handed from the shifter to the buffer control
`timescale 1ns/1ps
`default_nettype none
interface urb_frame_if;
  logic       valid;
  logic [8:0] data;
  logic       stop_fault;
  logic       parity_fault;
  logic       start_seen;
  modport src (output valid, data, stop_fault, parity_fault, start_seen);
  modport dst (input valid, data, stop_fault, parity_fault, start_seen);
endinterface : urb_frame_if
`default_nettype wire

//--- rtl/urb_entry_mem.sv
// receive buffer storage, registered read with write forwarding
`timescale 1ns/1ps
`default_nettype none
module urb_entry_mem import urb_pkg::*; #(
  parameter int W     = ENT_W,
  parameter int DEPTH = BUF_DEPTH
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_srst,
  input  wire logic                     i_we,
  input  wire logic [$clog2(DEPTH)-1:0] i_waddr,
  input  wire logic [W-1:0]             i_wdata,
  input  wire logic [$clog2(DEPTH)-1:0] i_raddr,
  output logic      [W-1:0]             o_rdata
);
  logic [W-1:0] mem_r [DEPTH];
  wire          fwd = i_we && (i_waddr == i_raddr);

  if (DEPTH < 2) begin : g_chk
    $error("urb_entry_mem needs at least two entries");
  end

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_r[i_waddr] <= i_wdata;
    end
  end

  // forwarding keeps the head visible in the same cycle it lands
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= fwd ? i_wdata : mem_r[i_raddr];
    end
  end
endmodule : urb_entry_mem
`default_nettype wire

//--- rtl/urb_rx_shifter.sv
// serial frame shifter: start check, data, parity, first stop bit
`timescale 1ns/1ps
`default_nettype none
module urb_rx_shifter import urb_pkg::*; #(
  parameter int BIT_CYC = BIT_CYCLES
) (
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic       i_rxd,
  input  wire logic       i_enable,
  input  wire logic [2:0] i_char_size,
  input  wire logic       i_parity_on,
  input  wire logic       i_parity_odd,
  urb_frame_if.src        o_frame
);
  localparam int CW = $clog2(BIT_CYC + 1);
  localparam logic [CW-1:0] FULL = CW'(BIT_CYC - 1);
  localparam logic [CW-1:0] HALF = CW'(BIT_CYC / 2 - 1);

  if (BIT_CYC < 4) begin : g_chk
    $error("urb_rx_shifter needs at least four cycles per bit");
  end

  urb_rx_state_t state_r;
  logic          rxd_m_r, rxd_s_r, armed_r, par_r;
  logic [CW-1:0] cnt_r;
  logic [3:0]    idx_r;
  logic [8:0]    sh_r;
  logic          valid_r, start_r, fe_r, pe_r;

  wire       tick = (cnt_r == '0);
  // reserved sizes fall back to eight bits
  wire [3:0] last_idx = (i_char_size == CHAR_SIZE9) ? 4'h8 :
                        (i_char_size > 3'h3) ? 4'h7 : 4'h4 + {1'b0, i_char_size};

  always_ff @(posedge i_clk) begin
    rxd_m_r <= i_rxd;
    rxd_s_r <= rxd_m_r;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst || !i_enable) begin
      state_r <= RX_IDLE;
      cnt_r   <= '0;
      idx_r   <= '0;
      sh_r    <= '0;
      armed_r <= 1'b0;
      par_r   <= 1'b0;
      valid_r <= 1'b0;
      start_r <= 1'b0;
      fe_r    <= 1'b0;
      pe_r    <= 1'b0;
    end else begin
      valid_r <= 1'b0;
      start_r <= 1'b0;
      cnt_r   <= tick ? FULL : cnt_r - 1'b1;
      case (state_r)
        RX_IDLE: begin
          armed_r <= armed_r | rxd_s_r;
          if (armed_r && !rxd_s_r) begin
            state_r <= RX_START;
            cnt_r   <= HALF;
          end
        end
        RX_START: if (tick) begin
          // a start bit gone high by mid-bit is a glitch
          state_r <= rxd_s_r ? RX_IDLE : RX_DATA;
          start_r <= !rxd_s_r;
          idx_r   <= '0;
          sh_r    <= '0;
          par_r   <= 1'b0;
          pe_r    <= 1'b0;
        end
        RX_DATA: if (tick) begin
          sh_r[idx_r] <= rxd_s_r;
          par_r       <= par_r ^ rxd_s_r;
          idx_r       <= idx_r + 1'b1;
          if (idx_r == last_idx) begin
            state_r <= i_parity_on ? RX_PARITY : RX_STOP;
          end
        end
        RX_PARITY: if (tick) begin
          pe_r    <= par_r ^ rxd_s_r ^ i_parity_odd;
          state_r <= RX_STOP;
        end
        RX_STOP: if (tick) begin
          // only the first stop bit is looked at
          fe_r    <= !rxd_s_r;
          valid_r <= 1'b1;
          armed_r <= 1'b0;
          state_r <= RX_IDLE;
        end
        default: state_r <= RX_IDLE;
      endcase
    end
  end

  assign o_frame.valid        = valid_r;
  assign o_frame.data         = sh_r;
  assign o_frame.stop_fault   = fe_r;
  assign o_frame.parity_fault = pe_r;
  assign o_frame.start_seen   = start_r;
endmodule : urb_rx_shifter
`default_nettype wire

//--- rtl/urb_rx_top.sv
// usart receive buffer, status flags and axi4-lite register slave
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module urb_rx_top import urb_pkg::*; #(
  parameter int BIT_CYC = BIT_CYCLES
) (
  // clock and reset
  input  wire logic        I_MCLK,
  input  wire logic        I_SRST,
  // axi4-lite write address and data
  input  wire logic [7:0]  I_AWADDR,
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  // axi4-lite write response
  output logic [1:0]       O_BRESP,
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  // axi4-lite read
  input  wire logic [7:0]  I_ARADDR,
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP,
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  // serial line and pin override
  input  wire logic        I_RXD,
  output logic             O_RXD_OWNED,
  // receive complete request
  output logic             O_RXC_IRQ
);
  localparam int PW = $clog2(BUF_DEPTH);
  localparam int NW = $clog2(BUF_DEPTH + 1);
  localparam logic [NW-1:0] FULL_CNT = NW'(BUF_DEPTH);

  // pointers wrap by overflow, so the depth has to be a power of two
  if ((BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_chk_depth
    $error("urb_rx_top needs a power-of-two buffer depth");
  end
  if (BIT_CYC < 4) begin : g_chk_bit
    $error("urb_rx_top needs at least four cycles per bit");
  end

  // configuration
  logic       irq_en_r, rx_on_r, par_on_r, odd_r, stop2_r;
  logic [2:0] size_r;

  // buffer control
  logic [NW-1:0]    count_r;
  logic [PW-1:0]    head_r, tail_r;
  logic             pend_v_r, ovr_r;
  logic [ENT_W-1:0] pend_r, head_ent;

  // bus state
  logic        aw_have_r, w_have_r, awready_r, wready_r, bvalid_r;
  logic [7:0]  awaddr_r;
  logic [7:0]  wdata_r;
  logic        wstrb0_r;
  logic [1:0]  bresp_r;
  logic        arready_r, rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic        owned_r, irq_r;

  urb_frame_if frame ();

  urb_rx_shifter #(.BIT_CYC(BIT_CYC)) u_shift (
    .i_clk        (I_MCLK),
    .i_srst       (I_SRST),
    .i_rxd        (I_RXD),
    .i_enable     (rx_on_r),
    .i_char_size  (size_r),
    .i_parity_on  (par_on_r),
    .i_parity_odd (odd_r),
    .o_frame      (frame.src)
  );

  // write channel decode
  wire aw_take  = I_AWVALID & awready_r;
  wire w_take   = I_WVALID & wready_r;
  wire do_write = aw_have_r & w_have_r;
  wire w_hit    = (awaddr_r[7:4] == 4'h0);
  wire w_lane   = do_write & w_hit & wstrb0_r;
  wire wr_ctrl  = w_lane & (awaddr_r[3:2] == OFF_CONTROL[3:2]);
  wire wr_frame = w_lane & (awaddr_r[3:2] == OFF_FRAME[3:2]);
  // clearing receiver_on flushes at the write edge itself, so no stale request follows
  wire flush    = wr_ctrl & ~wdata_r[CT_RX_ON];

  // a held address or data word blocks its channel until the response is taken
  wire aw_have_nxt = do_write ? 1'b0 : (aw_have_r | aw_take);
  wire w_have_nxt  = do_write ? 1'b0 : (w_have_r | w_take);
  wire bvalid_nxt  = do_write | (bvalid_r & ~I_BREADY);
  wire awready_nxt = ~aw_have_nxt & ~bvalid_nxt;
  wire wready_nxt  = ~w_have_nxt & ~bvalid_nxt;

  // read channel decode
  wire       ar_take    = I_ARVALID & arready_r;
  wire       r_hit      = (I_ARADDR[7:4] == 4'h0);
  wire [1:0] r_word     = I_ARADDR[3:2];
  wire       unread     = (count_r != '0);
  wire       sel_status  = (r_word == OFF_STATUS[3:2]);
  wire       sel_control = (r_word == OFF_CONTROL[3:2]);
  wire       sel_frame   = (r_word == OFF_FRAME[3:2]);
  wire       sel_data    = (r_word == OFF_DATA[3:2]);
  wire       pop        = ar_take & r_hit & sel_data & unread;
  wire       rvalid_nxt = ar_take | (rvalid_r & ~I_RREADY);

  // head flags only mean something while a character is held
  wire fe_flag   = unread & head_ent[ENT_FE];
  wire lost_flag = unread & head_ent[ENT_LOST];
  wire pe_flag   = unread & head_ent[ENT_PE];
  wire ninth     = unread & head_ent[8];

  // register images placed by the package field positions
  wire [7:0] status_v  = (8'(unread) << ST_UNREAD) |
                         (8'(fe_flag) << ST_FE) |
                         (8'(lost_flag) << ST_LOST) |
                         (8'(pe_flag) << ST_PE);
  wire [7:0] control_v = (8'(irq_en_r) << CT_IRQ_EN) |
                         (8'(rx_on_r) << CT_RX_ON) |
                         (8'(ninth) << CT_NINTH);
  wire [7:0] frame_v   = (8'(par_on_r) << FC_PAR_ON) |
                         (8'(odd_r) << FC_ODD) |
                         (8'(stop2_r) << FC_STOP2) |
                         (8'(size_r) << FC_SIZE);
  wire [7:0] data_v    = unread ? head_ent[7:0] : 8'h00;
  wire [7:0] rd_mux    = sel_status  ? status_v  :
                         sel_control ? control_v :
                         sel_frame   ? frame_v   : data_v;

  // buffer fill: the shifter-held character goes first, new frame waits
  wire room     = (count_r != FULL_CNT) | pop;
  wire push_old = pend_v_r & room;
  wire push_new = frame.valid & ~pend_v_r & room;
  wire we       = push_old | push_new;
  wire [ENT_W-1:0] new_ent = (ENT_W'(frame.stop_fault) << ENT_FE) |
                             (ENT_W'(frame.parity_fault) << ENT_PE) |
                             ENT_W'(frame.data);
  wire [ENT_W-1:0] src_ent = push_old ? pend_r : new_ent;
  wire [ENT_W-1:0] w_ent   = (src_ent & ~(ENT_W'(1) << ENT_LOST)) |
                             (ENT_W'(ovr_r) << ENT_LOST);
  wire hold_new  = frame.valid & ~push_new;
  // overrun needs the start of yet another frame, not only a held one
  wire ovr_set   = frame.start_seen & (count_r == FULL_CNT) & pend_v_r;
  wire [NW-1:0]  count_nxt = count_r + NW'(we) - NW'(pop);
  wire [PW-1:0]  head_nxt  = pop ? head_r + 1'b1 : head_r;

  urb_entry_mem #(.W(ENT_W), .DEPTH(BUF_DEPTH)) u_mem (
    .i_clk   (I_MCLK),
    .i_srst  (I_SRST),
    .i_we    (we),
    .i_waddr (tail_r),
    .i_wdata (w_ent),
    .i_raddr (rx_on_r ? head_nxt : '0),
    .o_rdata (head_ent)
  );

  // configuration registers; the status register takes no writes
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      irq_en_r <= CONTROL_RST[CT_IRQ_EN];
      rx_on_r  <= CONTROL_RST[CT_RX_ON];
      par_on_r <= FRAME_RST[FC_PAR_ON];
      odd_r    <= FRAME_RST[FC_ODD];
      stop2_r  <= FRAME_RST[FC_STOP2];
      size_r   <= FRAME_RST[FC_SIZE +: 3];
    end else begin
      if (wr_ctrl) begin
        irq_en_r <= wdata_r[CT_IRQ_EN];
        rx_on_r  <= wdata_r[CT_RX_ON];
      end
      if (wr_frame) begin
        par_on_r <= wdata_r[FC_PAR_ON];
        odd_r    <= wdata_r[FC_ODD];
        stop2_r  <= wdata_r[FC_STOP2];
        size_r   <= wdata_r[FC_SIZE +: 3];
      end
    end
  end

  // buffer pointers, held character and overrun
  always_ff @(posedge I_MCLK) begin
    if (I_SRST || !rx_on_r || flush) begin
      count_r  <= '0;
      head_r   <= '0;
      tail_r   <= '0;
      pend_v_r <= 1'b0;
      pend_r   <= '0;
      ovr_r    <= 1'b0;
    end else begin
      count_r  <= count_nxt;
      head_r   <= head_nxt;
      tail_r   <= we ? tail_r + 1'b1 : tail_r;
      pend_v_r <= hold_new | (pend_v_r & ~push_old);
      // a fourth frame while full overwrites the held third one
      if (hold_new) begin
        pend_r <= new_ent;
      end
      ovr_r <= ovr_set | (ovr_r & ~we);
    end
  end

  // axi write side
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      awaddr_r  <= 8'h00;
      wdata_r   <= 8'h00;
      wstrb0_r  <= 1'b0;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r  <= w_have_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      if (aw_take) begin
        awaddr_r <= I_AWADDR;
      end
      if (w_take) begin
        wdata_r  <= I_WDATA[7:0];
        wstrb0_r <= I_WSTRB[0];
      end
      if (do_write) begin
        bresp_r <= w_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // axi read side
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= RESP_OKAY;
    end else begin
      arready_r <= ~rvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      if (ar_take) begin
        rdata_r <= r_hit ? {24'h00_0000, rd_mux} : 32'h0000_0000;
        rresp_r <= r_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // both lag their sources by one cycle so they stay plain flops at the pins
  wire owned_nxt = rx_on_r;
  wire irq_nxt   = irq_en_r & unread;

  // pin ownership and level request; error flags stay out of it
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      owned_r <= 1'b0;
      irq_r   <= 1'b0;
    end else begin
      owned_r <= owned_nxt;
      irq_r   <= irq_nxt;
    end
  end

  assign O_AWREADY   = awready_r;
  assign O_WREADY    = wready_r;
  assign O_BVALID    = bvalid_r;
  assign O_BRESP     = bresp_r;
  assign O_ARREADY   = arready_r;
  assign O_RVALID    = rvalid_r;
  assign O_RDATA     = rdata_r;
  assign O_RRESP     = rresp_r;
  assign O_RXD_OWNED = owned_r;
  assign O_RXC_IRQ   = irq_r;
endmodule : urb_rx_top
`default_nettype wire

//--- bench/urb_rx_properties.sv
// port-level assertions for the usart receive buffer top
`timescale 1ns/1ps
`default_nettype none
module urb_rx_checker import urb_pkg::*; #(
  parameter int BIT_CYC = BIT_CYCLES
) (
  input wire logic        I_MCLK,
  input wire logic        I_SRST,
  input wire logic [7:0]  I_AWADDR,
  input wire logic        I_AWVALID,
  input wire logic        O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic        I_WVALID,
  input wire logic        O_WREADY,
  input wire logic        O_BVALID,
  input wire logic [7:0]  I_ARADDR,
  input wire logic        I_ARVALID,
  input wire logic        O_ARREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic [1:0]  O_RRESP,
  input wire logic        O_RVALID,
  input wire logic        O_RXD_OWNED,
  input wire logic        O_RXC_IRQ
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_SRST);
  // shadows lag the real registers by one cycle, the same lag as irq and pin ownership
  logic [7:0] aw_a, w_d, ar_a, ctl_sh, frm_sh;
  logic       bv_q;
  wire        wr_done = O_BVALID && !bv_q;
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      ctl_sh <= CONTROL_RST;
      frm_sh <= FRAME_RST;
      bv_q   <= 1'b0;
    end else begin
      bv_q <= O_BVALID;
      if (I_AWVALID && O_AWREADY) aw_a <= I_AWADDR;
      if (I_WVALID && O_WREADY) w_d <= I_WDATA[7:0];
      if (I_ARVALID && O_ARREADY) ar_a <= I_ARADDR;
      if (wr_done && aw_a == OFF_CONTROL) ctl_sh <= w_d;
      if (wr_done && aw_a == OFF_FRAME) frm_sh <= w_d;
    end
  end
  property p_own_follow;
    O_RXD_OWNED == ctl_sh[CT_RX_ON];
  endproperty
  a_own_follow: assert property (p_own_follow) else $error("pin ownership off");
  property p_irq_off;
    !ctl_sh[CT_IRQ_EN] |-> !O_RXC_IRQ;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
  property p_flush;
    !ctl_sh[CT_RX_ON] |-> !O_RXC_IRQ;
  endproperty
  a_flush: assert property (p_flush) else $error("data left after disable");
  property p_irq_level;
    $rose(O_RVALID) && ar_a == OFF_STATUS && ctl_sh[CT_IRQ_EN] |-> O_RXC_IRQ == O_RDATA[ST_UNREAD];
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq not unread flag");
  property p_short_zero;
    $rose(O_RVALID) && ar_a == OFF_DATA && frm_sh[2:0] < 3'h3
      |-> (O_RDATA[7:0] & ~(8'hff >> (3'h3 - frm_sh[2:0]))) == 8'h00;
  endproperty
  a_short_zero: assert property (p_short_zero) else $error("upper data bits set");
  property p_rdata_hi;
    O_RVALID |-> O_RDATA[31:8] == 24'h0;
  endproperty
  a_rdata_hi: assert property (p_rdata_hi) else $error("read data upper bytes set");
  property p_ar_answer;
    I_ARVALID && O_ARREADY |=> O_RVALID;
  endproperty
  a_ar_answer: assert property (p_ar_answer) else $error("late read answer");
  property p_ar_block;
    O_RVALID |-> !O_ARREADY;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read accepted while busy");
  property p_w_answer;
    I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##[1:2] O_BVALID;
  endproperty
  a_w_answer: assert property (p_w_answer) else $error("late write answer");
  property p_unmapped;
    $rose(O_RVALID) && ar_a[7:4] != 4'h0 |-> O_RRESP == RESP_SLVERR && O_RDATA == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read answer");
endmodule : urb_rx_checker
bind urb_rx_top urb_rx_checker #(.BIT_CYC(BIT_CYC)) u_chk (
  .I_MCLK(I_MCLK), .I_SRST(I_SRST), .I_AWADDR(I_AWADDR), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY),
  .I_WDATA(I_WDATA), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BVALID(O_BVALID), .I_ARADDR(I_ARADDR),
  .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA), .O_RRESP(O_RRESP), .O_RVALID(O_RVALID),
  .O_RXD_OWNED(O_RXD_OWNED), .O_RXC_IRQ(O_RXC_IRQ)
);
`default_nettype wire

//--- bench/urb_serial_tx.sv
// remote serial transmitter model driving the receive line
`timescale 1ns/1ps
`default_nettype none
module urb_serial_tx #(
  parameter int BIT_CYC = 16
) (
  // clock
  input  wire logic i_clk,
  // serial line, idles high
  output logic      o_line
);
  initial o_line = 1'b1;
  // lsb first, one whole bit time per bit
  task automatic send(input logic [12:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk);
      o_line <= bits[i];
      repeat (BIT_CYC - 1) @(posedge i_clk);
    end
    @(posedge i_clk);
    o_line <= 1'b1;
  endtask : send
endmodule : urb_serial_tx
`default_nettype wire

//--- bench/usart_receive_buffer_status_test.sv
// self-checking bench for the usart receive buffer block
`timescale 1ns/1ps
`default_nettype none
module usart_receive_buffer_status_test import urb_pkg::*;;
  localparam int BC = 16;
  localparam logic [2:0] SZT [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h5};
  localparam logic [5:0] PET = 6'b010110;
  localparam logic [5:0] POT = 6'b010100;
  localparam logic [5:0] S2T = 6'b101000;
  logic        I_MCLK, I_SRST, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY;
  logic [7:0]  I_AWADDR, I_ARADDR;
  logic [31:0] I_WDATA;
  logic [3:0]  I_WSTRB;
  wire         O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_RXD_OWNED, O_RXC_IRQ, rxd;
  wire  [1:0]  O_BRESP, O_RRESP;
  wire  [31:0] O_RDATA;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          nb;
  logic        pon, podd;
  logic [31:0] seed;
  logic [7:0]  ctl;
  logic [11:0] q[$];
  initial begin
    I_MCLK = 1'b0;
    forever #20 I_MCLK = ~I_MCLK;
  end
  urb_rx_top #(.BIT_CYC(BC)) u_dut (
    .I_MCLK(I_MCLK), .I_SRST(I_SRST), .I_AWADDR(I_AWADDR), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY),
    .I_WDATA(I_WDATA), .I_WSTRB(I_WSTRB), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BRESP(O_BRESP),
    .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .I_ARADDR(I_ARADDR), .I_ARVALID(I_ARVALID),
    .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA), .O_RRESP(O_RRESP), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY),
    .I_RXD(rxd), .O_RXD_OWNED(O_RXD_OWNED), .O_RXC_IRQ(O_RXC_IRQ)
  );
  urb_serial_tx #(.BIT_CYC(BC)) u_tx (.i_clk(I_MCLK), .o_line(rxd));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge I_MCLK);
    I_AWADDR <= a;
    I_WDATA <= {seed[31:8], d};
    I_WSTRB <= seed[3:0] | 4'h1;
    I_AWVALID <= 1'b1;
    I_WVALID <= 1'b1;
    I_BREADY <= 1'b1;
    while (1'b1) begin
      @(posedge I_MCLK);
      if (O_AWREADY) I_AWVALID <= 1'b0;
      if (O_WREADY) I_WVALID <= 1'b0;
      if (O_BVALID) break;
    end
    chk({30'h0, O_BRESP}, {30'h0, (a[7:4] != 4'h0) ? RESP_SLVERR : RESP_OKAY});
    I_BREADY <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge I_MCLK);
    I_ARADDR <= a;
    I_ARVALID <= 1'b1;
    I_RREADY <= 1'b1;
    while (1'b1) begin
      @(posedge I_MCLK);
      if (O_ARREADY) I_ARVALID <= 1'b0;
      if (O_RVALID) break;
    end
    d = O_RDATA;
    chk({30'h0, O_RRESP}, {30'h0, (a[7:4] != 4'h0) ? RESP_SLVERR : RESP_OKAY});
    I_RREADY <= 1'b0;
  endtask : rd
  task automatic setc(input logic [7:0] v);
    ctl = v;
    wr(OFF_CONTROL, v);
  endtask : setc
  task automatic cfg(input logic [2:0] sz, input logic pe, input logic po, input logic s2);
    wr(OFF_FRAME, {2'b00, pe, po, s2, sz});
    nb = (sz == CHAR_SIZE9) ? 9 : (sz > 3'h3) ? 8 : 5 + int'(sz);
    pon = pe;
    podd = po;
  endtask : cfg
  // bp flips the parity bit, sb pulls the first stop bit low; trailing bit is always high
  task automatic snd(input logic bp, input logic sb);
    logic [12:0] b;
    logic [8:0]  d;
    int          n;
    seed = lfsr(seed);
    d = seed[8:0] & ~(9'h1ff << nb);
    b = 13'h1fff;
    b[0] = 1'b0;
    for (int i = 0; i < nb; i++) b[i + 1] = d[i];
    n = nb + 1;
    if (pon) begin
      b[n] = (^d) ^ podd ^ bp;
      n++;
    end
    b[n] = ~sb;
    n += 2;
    q.push_back({1'b0, sb, pon & bp, d});
    u_tx.send(b, n);
  endtask : snd
  // status and ninth bit are read before the data byte that pops them
  task automatic pop_chk();
    logic [11:0] e;
    logic [31:0] d;
    logic        h;
    h = q.size() != 0;
    e = 12'h0;
    if (h) e = q.pop_front();
    seed = lfsr(seed);
    wr(OFF_STATUS, seed[7:0]);
    rd(OFF_STATUS, d);
    chk(d, {24'h0, h, 2'b00, e[ENT_FE], e[ENT_LOST], e[ENT_PE], 2'b00});
    rd(OFF_CONTROL, d);
    chk(d, {24'h0, ctl | {6'h0, e[8], 1'b0}});
    rd(OFF_DATA, d);
    chk(d, {24'h0, e[7:0]});
  endtask : pop_chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (40000) @(posedge I_MCLK);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    logic [31:0] d;
    I_SRST = 1'b1;
    {I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY} = 5'h0;
    {I_AWADDR, I_ARADDR, I_WDATA, I_WSTRB} = 52'h0;
    seed = 32'hea6a;
    ctl = 8'h00;
    repeat (20) @(posedge I_MCLK);
    I_SRST <= 1'b0;
    rd(OFF_FRAME, d);
    chk(d, {24'h0, FRAME_RST});
    rd(8'h40, d);
    wr(8'h40, 8'h5a);
    pop_chk();
    $display("test reset done");
    setc(8'h90);
    for (int k = 0; k < 6; k++) begin
      cfg(SZT[k], PET[k], POT[k], S2T[k]);
      snd(seed[0], seed[1]);
      snd(seed[2], 1'b0);
      repeat (3) pop_chk();
      snd(seed[3], seed[4]);
      pop_chk();
      $display("test mode %0d done", k);
    end
    cfg(3'h3, 1'b0, 1'b0, 1'b0);
    repeat (4) snd(1'b0, 1'b0);
    q.delete(2);
    q[2][ENT_LOST] = 1'b1;
    repeat (3) pop_chk();
    snd(1'b0, 1'b0);
    repeat (2) pop_chk();
    $display("test overrun done");
    repeat (2) snd(1'b0, 1'b0);
    setc(8'h80);
    q.delete();
    pop_chk();
    setc(8'h90);
    fork
      snd(1'b0, 1'b0);
      begin
        repeat (5 * BC) @(posedge I_MCLK);
        setc(8'h80);
      end
    join
    q.delete();
    setc(8'h90);
    pop_chk();
    $display("test disable done");
    repeat (2) snd(1'b0, 1'b0);
    q.delete();
    for (int i = 0; i < 4; i++) begin
      rd(OFF_STATUS, d);
      if (d[ST_UNREAD] === 1'b1) rd(OFF_DATA, d);
    end
    pop_chk();
    $display("test software flush done");
    wrap_up();
  end
endmodule : usart_receive_buffer_status_test
`default_nettype wire
